// *** ccint_pkg.sv ***
/*
 * Package for the comparator change interrupt block: register offsets,
 * field positions, reset values, clock phase codes and engine states.
 * Assumes a 32-bit AXI4-Lite register bus with byte addressing.
 */
`default_nettype none

package ccint_pkg;

    // =========================================================
    // bus geometry
    // =========================================================
    localparam int          CCINT_ADDR_W   = 8;
    localparam int          CCINT_DATA_W   = 32;
    localparam int          CCINT_NUM_CMP  = 2;

    // =========================================================
    // register offsets (byte addresses)
    // =========================================================
    localparam logic [7:0]  OFS_CTRL0      = 8'h00;  // comparator_control_reg, comparator 1
    localparam logic [7:0]  OFS_CTRL1      = 8'h04;  // comparator_control_reg, comparator 2
    localparam logic [7:0]  OFS_AUX        = 8'h08;  // comparator_aux_control_reg
    localparam logic [7:0]  OFS_FLAG       = 8'h0C;  // peripheral_flag_reg_two
    localparam logic [7:0]  OFS_ENABLE     = 8'h10;  // peripheral_enable_reg_two
    localparam logic [7:0]  OFS_INTCTL     = 8'h14;  // interrupt_control_reg
    localparam logic [7:0]  OFS_CTRL_STEP  = 8'h04;

    // =========================================================
    // field positions
    // =========================================================
    localparam int          BIT_ON         = 7;      // comparator_on
    localparam int          BIT_OUT        = 6;      // comparator_output_bit, read only
    localparam int          BIT_OE         = 5;      // comparator_pin_output_enable
    localparam int          BIT_POL        = 4;      // comparator_output_invert
    localparam int          BIT_PERIPH_EN  = 0;      // peripheral_low_int_enable
    localparam int          BIT_GLOBAL_EN  = 1;      // global_high_int_enable

    // =========================================================
    // reset values
    // =========================================================
    localparam logic [2:0]  RST_CTRL       = 3'h0;   // {on, oe, pol}
    localparam logic [1:0]  RST_FLAG       = 2'h0;
    localparam logic [1:0]  RST_ENABLE     = 2'h0;
    localparam logic [1:0]  RST_INTCTL     = 2'h0;
    localparam logic        RST_LATCH      = 1'b0;

    // =========================================================
    // instruction cycle phases: four aclk cycles per instruction cycle
    // =========================================================
    localparam logic [1:0]  PH_Q1          = 2'h0;
    localparam logic [1:0]  PH_Q2          = 2'h1;
    localparam logic [1:0]  PH_Q3          = 2'h2;
    localparam logic [1:0]  PH_Q4          = 2'h3;

    localparam logic [1:0]  RESP_OKAY      = 2'h0;
    localparam logic [1:0]  RESP_SLVERR    = 2'h2;

    // =========================================================
    // access engine states
    // =========================================================
    typedef enum logic [4:0] {
        ST_IDLE  = 5'b00001,
        ST_WAIT3 = 5'b00010,
        ST_WAIT4 = 5'b00100,
        ST_BRESP = 5'b01000,
        ST_RRESP = 5'b10000
    } ccint_state_t;

endpackage

`default_nettype wire

// *** ccint_top.sv ***
/*
 * Comparator change interrupt block: two comparators, each with a
 * reference latch and a tracking latch, a mismatch edge detector, an
 * interrupt flag, enable gating and an AXI4-Lite register slave.
 * Assumes comparator results arrive synchronous to aclk.
 */
// Design decisions made here: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/10ps
`default_nettype none

// Summary of operation
// RULE1: flag sets when comparator output changes, seen via reference versus tracking latch.
// RULE2: any control register access loads reference latch with output at Q3.
// RULE3: reference latch holds until next control register access or reset.
// RULE4: tracking latch loads comparator output at every Q1.
// RULE5: mismatch is xor of the two latches, fed to interrupt logic.
// RULE6: mismatch stays until reference refresh or output returns.
// RULE7: control register writes also clear mismatch through their leading read.
// RULE8: detection ignores the pin output enable bit.
// RULE9: flag sets on mismatch rising edge, not its level.
// RULE10: return to old level interrupts only if latches were cleared.
// RULE11: software clears flag by writing zero; writing one sets it.
// RULE12: request reaches processor only with all three enables set.
// RULE13: flag sets regardless of enable bits.
// RULE14: while comparator off, polarity bit drives the output level.
// RULE15: preset write: latches load in read phase, new settings apply in write phase.
// RULE16: output change during a read at Q2 may miss the flag.
// RULE17: software waits bias settling, clears mismatch and flag, then enables interrupts.
// RULE18: software tracks output history to find change direction.
// RULE19: each comparator has its own latch pair and flag.
module ccint_top
    import ccint_pkg::*;
#(
    parameter int NUM_CMP = CCINT_NUM_CMP
)(
    input  wire logic                    aclk,
    input  wire logic                    aresetn,
    input  wire logic [NUM_CMP-1:0]      cmp_raw,
    output logic      [NUM_CMP-1:0]      cmp_pin_out,
    output logic      [NUM_CMP-1:0]      cmp_pin_en,
    output logic                         irq,
    input  wire logic [CCINT_ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                    s_axi_awvalid,
    output logic                         s_axi_awready,
    input  wire logic [CCINT_DATA_W-1:0] s_axi_wdata,
    input  wire logic [3:0]              s_axi_wstrb,
    input  wire logic                    s_axi_wvalid,
    output logic                         s_axi_wready,
    output logic      [1:0]              s_axi_bresp,
    output logic                         s_axi_bvalid,
    input  wire logic                    s_axi_bready,
    input  wire logic [CCINT_ADDR_W-1:0] s_axi_araddr,
    input  wire logic                    s_axi_arvalid,
    output logic                         s_axi_arready,
    output logic      [CCINT_DATA_W-1:0] s_axi_rdata,
    output logic      [1:0]              s_axi_rresp,
    output logic                         s_axi_rvalid,
    input  wire logic                    s_axi_rready
);

    // =========================================================
    // state
    // =========================================================
    ccint_state_t              st_q, st_d;
    logic [1:0]                phase_q;
    logic                      aw_got_q, w_got_q, is_wr_q;
    logic [CCINT_ADDR_W-1:0]   addr_q;
    logic [7:0]                wdata_q;
    logic                      wen_q;
    logic [CCINT_DATA_W-1:0]   rdata_q;
    logic [1:0]                rresp_q, bresp_q;
    logic [2:0]                ctrl_q    [NUM_CMP];
    logic [NUM_CMP-1:0]        ref_q, track_q, mis_q, flag_q, flag_d;
    logic [1:0]                enable_q, intctl_q;

    wire                       at_q1     = (phase_q == PH_Q1);
    wire                       at_q3     = (phase_q == PH_Q3);
    wire                       at_q4     = (phase_q == PH_Q4);
    wire                       idle      = (st_q == ST_IDLE);
    wire                       aw_hs     = s_axi_awvalid & s_axi_awready;
    wire                       w_hs      = s_axi_wvalid & s_axi_wready;
    wire                       ar_hs     = s_axi_arvalid & s_axi_arready;
    wire                       start_wr  = idle & aw_got_q & w_got_q;
    wire                       read_ph   = (st_q == ST_WAIT3) & at_q3;
    wire                       write_ph  = (st_q == ST_WAIT4) & at_q4 & wen_q;

    // =========================================================
    // instruction cycle phase counter
    // =========================================================
    // free running so that Q1 and Q3 recur every four aclk cycles
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            phase_q <= PH_Q1;
        else
            phase_q <= phase_q + 2'h1;
    end

    // =========================================================
    // per comparator latches, mismatch and pin drive
    // =========================================================
    logic [NUM_CMP-1:0]        cmp_level;
    logic [NUM_CMP-1:0]        ctrl_hit;
    logic [NUM_CMP-1:0]        mis_now;

    genvar gi;
    generate
        for (gi = 0; gi < NUM_CMP; gi++)
        begin : g_cmp
            wire on_b  = ctrl_q[gi][2];
            wire oe_b  = ctrl_q[gi][1];
            wire pol_b = ctrl_q[gi][0];

            // off comparator shows the polarity bit, on shows the result xored with the polarity bit
            assign cmp_level[gi] = on_b ? (cmp_raw[gi] ^ pol_b) : pol_b; // RULE14
            assign ctrl_hit[gi]  = (addr_q == OFS_CTRL0 + 8'(gi) * OFS_CTRL_STEP);
            assign mis_now[gi]   = ref_q[gi] ^ track_q[gi]; // RULE5 RULE6 RULE8
            // pin follows the latched result only while enabled and on
            assign cmp_pin_en[gi]  = oe_b & on_b;
            assign cmp_pin_out[gi] = track_q[gi];

            // reference latch: loaded by the read phase of any access to its own control reg
            always_ff @(posedge aclk)
            begin
                if (!aresetn)
                    ref_q[gi] <= RST_LATCH;
                else if (read_ph && ctrl_hit[gi]) // RULE2 RULE3 RULE7 RULE15 RULE19
                    ref_q[gi] <= cmp_level[gi];
            end

            // tracking latch: loaded on every Q1
            always_ff @(posedge aclk)
            begin
                if (!aresetn)
                    track_q[gi] <= RST_LATCH;
                else if (at_q1) // RULE4
                    track_q[gi] <= cmp_level[gi];
            end

            // control fields change only in the write phase, after the reference load
            always_ff @(posedge aclk)
            begin
                if (!aresetn)
                    ctrl_q[gi] <= RST_CTRL;
                else if (write_ph && ctrl_hit[gi]) // RULE15
                    ctrl_q[gi] <= {wdata_q[BIT_ON], wdata_q[BIT_OE], wdata_q[BIT_POL]};
            end
        end
    endgenerate

    // =========================================================
    // mismatch edge and interrupt flag
    // =========================================================
    // edge detection lets software clear the flag while the mismatch still stands
    wire [NUM_CMP-1:0]         set_edge  = mis_now & ~mis_q; // RULE1 RULE9 RULE10 RULE13
    wire                       flag_wr   = write_ph & (addr_q == OFS_FLAG);

    // software value first, hardware set on top so a coincident event is kept
    always_comb
    begin
        flag_d = flag_wr ? wdata_q[NUM_CMP-1:0] : flag_q; // RULE11
        flag_d = flag_d | set_edge;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            mis_q  <= '0;
            flag_q <= RST_FLAG;
        end
        else
        begin
            mis_q  <= mis_now;
            flag_q <= flag_d;
        end
    end

    // all three enables must be set for the request to leave the block
    assign irq = (|(flag_q & enable_q)) & intctl_q[BIT_PERIPH_EN] & intctl_q[BIT_GLOBAL_EN]; // RULE12

    // =========================================================
    // enable and interrupt control registers
    // =========================================================
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            enable_q <= RST_ENABLE;
            intctl_q <= RST_INTCTL;
        end
        else
        begin
            if (write_ph && addr_q == OFS_ENABLE)
                enable_q <= wdata_q[1:0];
            if (write_ph && addr_q == OFS_INTCTL)
                intctl_q <= wdata_q[1:0];
        end
    end

    // =========================================================
    // read data selection
    // =========================================================
    // output bit reads the tracking latch; a change right at Q2 may race the
    // reference load and leave the flag unset, a known limitation // RULE16
    logic [CCINT_DATA_W-1:0]   rd_mux;
    logic                      addr_ok;

    always_comb
    begin
        rd_mux  = '0;
        addr_ok = 1'b1;
        case (addr_q)
            OFS_CTRL0:  rd_mux[7:0] = {ctrl_q[0][2], track_q[0], ctrl_q[0][1], ctrl_q[0][0], 4'h0};
            OFS_CTRL1:  rd_mux[7:0] = {ctrl_q[1][2], track_q[1], ctrl_q[1][1], ctrl_q[1][0], 4'h0};
            OFS_AUX:    rd_mux[1:0] = track_q[1:0];
            OFS_FLAG:   rd_mux[1:0] = flag_q[1:0];
            OFS_ENABLE: rd_mux[1:0] = enable_q;
            OFS_INTCTL: rd_mux[1:0] = intctl_q;
            default:    addr_ok     = 1'b0;
        endcase
    end

    // =========================================================
    // AXI4-Lite handshakes
    // =========================================================
    // writes win over reads; only one access is in flight at a time
    assign s_axi_awready = idle & ~aw_got_q;
    assign s_axi_wready  = idle & ~w_got_q;
    assign s_axi_arready = idle & ~aw_got_q & ~w_got_q & ~s_axi_awvalid & ~s_axi_wvalid;
    assign s_axi_bvalid  = (st_q == ST_BRESP);
    assign s_axi_rvalid  = (st_q == ST_RRESP);
    assign s_axi_bresp   = bresp_q;
    assign s_axi_rresp   = rresp_q;
    assign s_axi_rdata   = rdata_q;

    // engine: wait for Q3 (read phase), then Q4 for writes (write phase)
    always_comb
    begin
        st_d = st_q;
        case (st_q)
            ST_IDLE:  if (start_wr || ar_hs) st_d = ST_WAIT3;
            ST_WAIT3: if (at_q3) st_d = is_wr_q ? ST_WAIT4 : ST_RRESP;
            ST_WAIT4: if (at_q4) st_d = ST_BRESP;
            ST_BRESP: if (s_axi_bready) st_d = ST_IDLE;
            ST_RRESP: if (s_axi_rready) st_d = ST_IDLE;
            default:  st_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            st_q <= ST_IDLE;
        else
            st_q <= st_d;
    end

    // capture of address and data for the access in flight
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_got_q <= 1'b0;
            w_got_q  <= 1'b0;
            is_wr_q  <= 1'b0;
            addr_q   <= '0;
            wdata_q  <= '0;
            wen_q    <= 1'b0;
        end
        else
        begin
            if (aw_hs)
                addr_q <= {s_axi_awaddr[CCINT_ADDR_W-1:2], 2'h0};
            else if (ar_hs)
                addr_q <= {s_axi_araddr[CCINT_ADDR_W-1:2], 2'h0};
            if (w_hs)
            begin
                wdata_q <= s_axi_wdata[7:0];
                wen_q   <= s_axi_wstrb[0];
            end
            aw_got_q <= start_wr ? 1'b0 : (aw_got_q | aw_hs);
            w_got_q  <= start_wr ? 1'b0 : (w_got_q | w_hs);
            if (start_wr)
                is_wr_q <= 1'b1;
            else if (ar_hs)
                is_wr_q <= 1'b0;
        end
    end

    // responses are fixed at the read phase
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rdata_q <= '0;
            rresp_q <= RESP_OKAY;
            bresp_q <= RESP_OKAY;
        end
        else if (read_ph)
        begin
            rdata_q <= addr_ok ? rd_mux : '0;
            rresp_q <= addr_ok ? RESP_OKAY : RESP_SLVERR;
            bresp_q <= addr_ok ? RESP_OKAY : RESP_SLVERR;
        end
    end

endmodule

`default_nettype wire

// *** ccint_chk.sv ***
/* checker for ccint_top: port-level timing of latches, enables and bus.
   assumes one clock domain with a synchronous active-low reset. */
`timescale 1ns/10ps
`default_nettype none
module ccint_chk
    import ccint_pkg::*;
#(
    parameter int NUM_CMP = CCINT_NUM_CMP
)(
    input wire logic               aclk,
    input wire logic               aresetn,
    input wire logic [NUM_CMP-1:0] cmp_pin_out,
    input wire logic [NUM_CMP-1:0] cmp_pin_en,
    input wire logic               irq,
    input wire logic               s_axi_awvalid,
    input wire logic               s_axi_awready,
    input wire logic               s_axi_wvalid,
    input wire logic               s_axi_wready,
    input wire logic               s_axi_bvalid,
    input wire logic [7:0]         s_axi_araddr,
    input wire logic               s_axi_arvalid,
    input wire logic               s_axi_arready,
    input wire logic [31:0]        s_axi_rdata,
    input wire logic [1:0]         s_axi_rresp,
    input wire logic               s_axi_rvalid,
    input wire logic               s_axi_rready
);
    // ==========================================
    // properties
    // ==========================================
    // single domain, so one clocking and one disable serve all
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_track_spacing: assert property ($changed(cmp_pin_out) |=> $stable(cmp_pin_out)[*3])
        else $error("tracking output moved twice in one cycle");
    a_en_by_write: assert property ($changed(cmp_pin_en) |-> ##[0:1] s_axi_bvalid)
        else $error("pin enable changed without a write");
    a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:10] s_axi_rvalid)
        else $error("read not answered in time");
    a_wr_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##[1:10] s_axi_bvalid)
        else $error("write not answered in time");
    a_rd_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped before taken");
    a_bad_addr: assert property (s_axi_arvalid && s_axi_arready && {s_axi_araddr[7:2], 2'h0} > OFS_INTCTL
        |-> ##[1:10] (s_axi_rvalid && s_axi_rresp == RESP_SLVERR))
        else $error("unmapped read not refused");
    a_rdata_rsvd: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
        else $error("reserved read bits not zero");
    a_reset_quiet: assert property ($rose(aresetn) |-> !irq && cmp_pin_out == '0 && !s_axi_rvalid)
        else $error("outputs not cleared by reset");
endmodule

bind ccint_top ccint_chk #(.NUM_CMP(NUM_CMP)) u_chk (.*);
`default_nettype wire

// *** ccint_cmp_model.sv ***
/* comparator model: raw results follow a requested level after a lag.
   assumes the bench sets level and lag between bus accesses. */
`timescale 1ns/10ps
`default_nettype none
module ccint_cmp_model (
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic [1:0] level_req,
    input  wire logic [3:0] lag,
    output logic      [1:0] cmp_raw
);
    logic [3:0] wait_q;

    // lag lets a slow comparator be modelled as well as a prompt one
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cmp_raw <= 2'h0;
            wait_q  <= 4'h0;
        end
        else if (level_req == cmp_raw)
            wait_q <= 4'h0;
        else if (wait_q >= lag)
        begin
            cmp_raw <= level_req;
            wait_q  <= 4'h0;
        end
        else
            wait_q <= wait_q + 4'h1;
    end
endmodule
`default_nettype wire

// *** comparator_change_interrupt_tb_top.sv ***
/* testbench for ccint_top: register rows in a loop, then hand tests.
   assumes every bus phase completes well inside the run ceiling. */
`timescale 1ns/10ps
`default_nettype none
module comparator_change_interrupt_tb_top
    import ccint_pkg::*;
;
    typedef struct packed {
        logic        wr;
        logic [7:0]  a;
        logic [31:0] d;
        logic [31:0] x;
        logic [1:0]  r;
        logic        q;
    } ccint_row_t;
    localparam ccint_row_t ROWS [10] = '{
        '{1'b1, OFS_ENABLE, 32'h3, 32'h3, RESP_OKAY, 1'b0},
        '{1'b1, OFS_INTCTL, 32'h3, 32'h3, RESP_OKAY, 1'b0},
        '{1'b1, OFS_CTRL1, 32'h10, 32'h50, RESP_OKAY, 1'b1},
        '{1'b0, OFS_FLAG, 32'h0, 32'h2, RESP_OKAY, 1'b1},
        '{1'b1, OFS_FLAG, 32'h0, 32'h0, RESP_OKAY, 1'b0},
        '{1'b1, OFS_FLAG, 32'h1, 32'h1, RESP_OKAY, 1'b1},
        '{1'b1, OFS_INTCTL, 32'h1, 32'h1, RESP_OKAY, 1'b0},
        '{1'b1, OFS_FLAG, 32'h0, 32'h0, RESP_OKAY, 1'b0},
        '{1'b0, OFS_AUX, 32'h0, 32'h2, RESP_OKAY, 1'b0},
        '{1'b1, 8'h18, 32'hFF, 32'h0, RESP_SLVERR, 1'b0}};

    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [1:0]  level_req = 2'h0;
    logic [3:0]  lag = 4'h0;
    logic [1:0]  cmp_raw, cmp_pin_out, cmp_pin_en, s_axi_bresp, s_axi_rresp, rsp;
    logic        irq, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [31:0] s_axi_rdata, rd;
    logic [7:0]  s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    int          err_count = 0, n_compared = 0, cyc = 0;

    ccint_top #(.NUM_CMP(2)) dut (.*);
    ccint_cmp_model u_cmp (.aclk(aclk), .aresetn(aresetn), .level_req(level_req), .lag(lag), .cmp_raw(cmp_raw));

    // 200 MHz clock
    initial forever #2.5 aclk = ~aclk;

    // ==========================================
    // tasks
    // ==========================================
    task automatic close_out();
        $display("compared %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            err_count++;
            $display("ERROR %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    // ready and answers are sampled at the falling edge, where they are settled
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        logic aw_hit;
        logic w_hit;
        logic aw_pend;
        logic w_pend;
        aw_pend = 1'b1;
        w_pend = 1'b1;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        // pending state kept locally: the valids only take their new value later in this time step
        while (aw_pend || w_pend)
        begin
            @(negedge aclk);
            aw_hit = aw_pend && s_axi_awready;
            w_hit = w_pend && s_axi_wready;
            @(posedge aclk);
            if (aw_hit) s_axi_awvalid <= 1'b0;
            if (w_hit) s_axi_wvalid <= 1'b0;
            aw_pend = aw_pend && !aw_hit;
            w_pend = w_pend && !w_hit;
        end
        @(negedge aclk);
        while (!s_axi_bvalid) @(negedge aclk);
        rsp = s_axi_bresp;
        @(posedge aclk);
        s_axi_bready <= 1'b0;
    endtask

    task automatic axi_rd(input logic [7:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        @(negedge aclk);
        while (!s_axi_arready) @(negedge aclk);
        @(posedge aclk);
        s_axi_arvalid <= 1'b0;
        @(negedge aclk);
        while (!s_axi_rvalid) @(negedge aclk);
        rd = s_axi_rdata;
        rsp = s_axi_rresp;
        @(posedge aclk);
        s_axi_rready <= 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] x);
        axi_rd(a);
        check(rd, x);
    endtask

    // cut a hang short; the run needs well under a thousand cycles
    always @(posedge aclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            err_count++;
            close_out();
        end
    end

    // ==========================================
    // main sequence
    // ==========================================
    initial
    begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        for (int i = 0; i < 10; i++)
        begin
            if (ROWS[i].wr)
            begin
                axi_wr(ROWS[i].a, ROWS[i].d);
                check(32'(rsp), 32'(ROWS[i].r));
            end
            rd_chk(ROWS[i].a, ROWS[i].x);
            check(32'(rsp), 32'(ROWS[i].r));
            repeat (2) @(negedge aclk);
            check(32'(irq), 32'(ROWS[i].q));
            $display("row %0d done", i);
        end
        // edge-triggered flag on comparator 1, prompt then slow
        axi_wr(OFS_INTCTL, 32'h3);
        axi_wr(OFS_CTRL0, 32'hA0);
        check(32'(cmp_pin_en), 32'h1);
        level_req[0] <= 1'b1;
        repeat (12) @(negedge aclk);
        check(32'(irq), 32'h1);
        axi_wr(OFS_FLAG, 32'h0);
        repeat (8) @(posedge aclk);
        rd_chk(OFS_FLAG, 32'h0);
        level_req[0] <= 1'b0;
        repeat (12) @(posedge aclk);
        rd_chk(OFS_FLAG, 32'h0);
        lag <= 4'h5;
        level_req[0] <= 1'b1;
        repeat (20) @(posedge aclk);
        rd_chk(OFS_FLAG, 32'h1);
        rd_chk(OFS_CTRL0, 32'hE0);
        axi_wr(OFS_FLAG, 32'h0);
        level_req[0] <= 1'b0;
        repeat (20) @(posedge aclk);
        rd_chk(OFS_FLAG, 32'h1);
        check(32'(cmp_pin_out), 32'h2);
        $display("change detection done");
        // a write reloads the reference; enables off still let the flag set
        axi_wr(OFS_CTRL0, 32'hA0);
        axi_wr(OFS_INTCTL, 32'h0);
        axi_wr(OFS_FLAG, 32'h0);
        level_req[0] <= 1'b1;
        repeat (20) @(posedge aclk);
        rd_chk(OFS_FLAG, 32'h1);
        check(32'(irq), 32'h0);
        $display("write clear and gating done");
        // strobe off: write answered but ignored; its read answer then waits on a late rready
        s_axi_wstrb <= 4'h0;
        axi_wr(OFS_INTCTL, 32'h3);
        s_axi_wstrb <= 4'hF;
        s_axi_araddr <= OFS_INTCTL;
        s_axi_arvalid <= 1'b1;
        @(negedge aclk);
        while (!s_axi_arready) @(negedge aclk);
        @(posedge aclk);
        s_axi_arvalid <= 1'b0;
        repeat (10) @(posedge aclk);
        s_axi_rready <= 1'b1;
        @(negedge aclk);
        while (!s_axi_rvalid) @(negedge aclk);
        check(s_axi_rdata, 32'h0);
        check(32'(irq), 32'h0);
        @(posedge aclk);
        s_axi_rready <= 1'b0;
        $display("strobe and stall done");
        // preset comparator 2, then only its own flag moves
        level_req[1] <= 1'b1;
        repeat (12) @(posedge aclk);
        axi_wr(OFS_CTRL1, 32'h00);
        repeat (8) @(posedge aclk);
        axi_wr(OFS_FLAG, 32'h0);
        axi_wr(OFS_CTRL1, 32'h90);
        repeat (12) @(posedge aclk);
        rd_chk(OFS_FLAG, 32'h0);
        rd_chk(OFS_CTRL1, 32'h90);
        level_req[1] <= 1'b0;
        repeat (20) @(posedge aclk);
        rd_chk(OFS_FLAG, 32'h2);
        $display("preset done");
        // mid-run reset clears every register
        aresetn <= 1'b0;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        for (int k = 0; k < 6; k++)
            rd_chk(8'(k * 4), 32'h0);
        $display("reset done");
        close_out();
    end
endmodule
`default_nettype wire
